/* File: hw/qdfd_pkg.sv */
package qdfd_pkg;
  // channel count and diagnostic byte layout
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned DIAG_W      = 8;
  localparam int unsigned TEMP_LSB    = 0;
  localparam int unsigned LOAD_LSB    = 4;
  localparam int unsigned BIT_CNT_W   = 3;
  localparam logic [2:0]  BIT_CNT_TOP = 3'h7;
  // interrupt pulse timing
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned T_INT_MIN_US = 3;
  localparam int unsigned T_INT_MAX_US = 25;
  // pulse length taken from the minimum, well inside the maximum
  localparam int unsigned INT_CYCLES  = T_INT_MIN_US * CLK_MHZ;
  localparam int unsigned INT_CNT_W   = 12;
  localparam logic [INT_CNT_W-1:0] INT_CNT_LAST =
    INT_CNT_W'(INT_CYCLES - 1);
  localparam logic [INT_CNT_W-1:0] INT_CNT_ZERO = 12'h000;

  typedef struct packed {
    logic [NUM_CH-1:0] open_load;
    logic [NUM_CH-1:0] over_temperature;
  } qdfd_flags_t;

  typedef enum logic [0:0] {
    QDFD_IDLE  = 1'b0,
    QDFD_PULSE = 1'b1
  } qdfd_os_state_t;
endpackage : qdfd_pkg

/* File: hw/qdfd_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module qdfd_channel (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // synchronised channel inputs
  input  wire logic ctrl_i,
  input  wire logic over_temperature_i,
  input  wire logic open_load_i,
  // results
  output logic      gate_on_o,
  output logic      overtemp_flag_o,
  output logic      openload_flag_o
);
  logic ctrl_q;
  logic armed;
  logic temp_flag;
  logic load_flag;

  wire rise_w = ctrl_i & ~ctrl_q;
  wire fall_w = ~ctrl_i & ctrl_q;
  wire trip_w = over_temperature_i;
  wire load_set_w = open_load_i & ~ctrl_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q    <= 1'b0;
      armed     <= 1'b1;
      temp_flag <= 1'b0;
      load_flag <= 1'b0;
    end else begin
      ctrl_q <= ctrl_i;
      if (trip_w) begin
        armed     <= 1'b0;
        temp_flag <= 1'b1;
      end else if (rise_w) begin
        armed     <= 1'b1;
        temp_flag <= 1'b0;
      end
      if (load_set_w)
        load_flag <= 1'b1;
      else if (fall_w)
        load_flag <= 1'b0;
    end
  end

  assign gate_on_o       = armed & ctrl_i & rst_n_i;
  assign overtemp_flag_o = temp_flag;
  assign openload_flag_o = load_flag;

  // a_trip_gate_off
  a_trip_gate_off: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i) trip_w |=> !gate_on_o && overtemp_flag_o)
    else $error("gate still on after over-temperature");
  // a_openload_keeps_gate
  a_openload_keeps_gate: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (armed && !trip_w && ctrl_i) |=> (ctrl_i |-> gate_on_o))
    else $error("gate dropped without over-temperature");
  // a_open_clear_fall
  a_open_clear_fall: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (fall_w && !load_set_w) |=> !openload_flag_o)
    else $error("open-load flag not cleared on falling edge");
  // a_rearm_rise
  a_rearm_rise: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (rise_w && !trip_w) |=> armed && !overtemp_flag_o)
    else $error("latch not re-armed on rising edge");
endmodule : qdfd_channel
`default_nettype wire

/* File: hw/qdfd_shift.sv */
`timescale 1ns/1ps
`default_nettype none
module qdfd_shift (
  // serial link, own clock domain
  input  wire logic                  sck_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  sdi_i,
  // flags already held stable by the core domain
  input  wire qdfd_pkg::qdfd_flags_t flags_i,
  // serial output, three-state
  output logic                       sdo_o,
  output logic                       sdo_oe_n_o
);
  logic [qdfd_pkg::DIAG_W-1:0] snap;
  logic [qdfd_pkg::DIAG_W-1:0] shreg;
  logic                        first;
  logic                        out_bit;
  logic                        in_bit;

  // snapshot and shift register not reset
  always_ff @(negedge cs_n_i) begin
    snap <= flags_i;
  end

  // first rising sck of a frame takes the snapshot
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i)
      first <= 1'b1;
    else
      first <= 1'b0;
  end

  always_ff @(posedge sck_i) begin
    if (first)
      shreg <= {snap[qdfd_pkg::DIAG_W-2:0], in_bit};
    else
      shreg <= {shreg[qdfd_pkg::DIAG_W-2:0], in_bit};
  end

  always_ff @(negedge sck_i) begin
    in_bit <= sdi_i;
  end

  assign out_bit = first ? snap[qdfd_pkg::DIAG_W-1]
                         : shreg[qdfd_pkg::DIAG_W-1];

  assign sdo_o      = out_bit;
  assign sdo_oe_n_o = cs_n_i;
endmodule : qdfd_shift
`default_nettype wire

/* File: hw/qdfd_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - over-current never switches output off
// - over-temperature clears latch, sets flag
// - shutdown ignores control input level
// - control rising edge re-arms, clears flag
// - persistent heat repeats shutdown
// - open load flagged while off
// - control falling edge clears open-load
// - open load never forces output off
// - open load redetected every off period
// - flags ORed into interrupt one-shot
// - interrupt pulse 3 to 25 us
// - triggers ignored during pulse
// - open-load reaches register and interrupt
// - all eight flags readable serially
// - interrupt is open-drain, wired-OR
// - bits 0-3 temperature, 4-7 open-load
// - reset clears flags, disables outputs
// - chip-select fall loads flags
// - msb out on rising, in falling
module qdfd_top (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_n_i,
  // channel control and analog sense, asynchronous
  input  wire logic [qdfd_pkg::NUM_CH-1:0]   ctrl_i,
  input  wire logic [qdfd_pkg::NUM_CH-1:0]   over_temperature_i,
  input  wire logic [qdfd_pkg::NUM_CH-1:0]   open_load_i,
  input  wire logic [qdfd_pkg::NUM_CH-1:0]   over_current_i,
  // gate drive
  output logic      [qdfd_pkg::NUM_CH-1:0]   gate_on_o,
  output logic      [qdfd_pkg::NUM_CH-1:0]   current_limit_o,
  // interrupt, open-drain
  output logic                               int_o,
  output logic                               int_oe_n_o,
  // serial link
  input  wire logic                          sck_i,
  input  wire logic                          cs_n_i,
  input  wire logic                          sdi_i,
  output logic                               sdo_o,
  output logic                               sdo_oe_n_o
);
  logic [qdfd_pkg::NUM_CH-1:0] ctrl_m, ctrl_s;
  logic [qdfd_pkg::NUM_CH-1:0] temp_m, temp_s;
  logic [qdfd_pkg::NUM_CH-1:0] load_m, load_s;
  logic [qdfd_pkg::NUM_CH-1:0] temp_flag, load_flag;
  logic [qdfd_pkg::NUM_CH-1:0] limit_hold;
  logic [qdfd_pkg::INT_CNT_W:0] int_len;
  qdfd_pkg::qdfd_flags_t       flags;
  qdfd_pkg::qdfd_flags_t       flags_prev;
  qdfd_pkg::qdfd_os_state_t    os_state, next_os_state;
  logic [qdfd_pkg::INT_CNT_W-1:0] os_cnt, next_os_cnt;
  logic                        int_active;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_m <= '0;
      ctrl_s <= '0;
      temp_m <= '0;
      temp_s <= '0;
      load_m <= '0;
      load_s <= '0;
    end else begin
      ctrl_m <= ctrl_i;
      ctrl_s <= ctrl_m;
      temp_m <= over_temperature_i;
      temp_s <= temp_m;
      load_m <= open_load_i;
      load_s <= load_m;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < qdfd_pkg::NUM_CH; ch++) begin : g_ch
      qdfd_channel u_ch (
        .core_clk_i         (core_clk_i),
        .rst_n_i            (rst_n_i),
        .ctrl_i             (ctrl_s[ch]),
        .over_temperature_i (temp_s[ch]),
        .open_load_i        (load_s[ch]),
        .gate_on_o          (gate_on_o[ch]),
        .overtemp_flag_o    (temp_flag[ch]),
        .openload_flag_o    (load_flag[ch])
      );

      // a_open_sets_flag
      a_open_sets_flag: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (load_s[ch] && !ctrl_s[ch]) |=> load_flag[ch])
        else $error("open-load flag not set while off");
      // a_heat_trips
      a_heat_trips: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        temp_s[ch] |=> temp_flag[ch] && !gate_on_o[ch])
        else $error("over-temperature did not trip channel");
    end
  endgenerate

  assign current_limit_o = over_current_i & gate_on_o;

  assign flags.over_temperature = temp_flag;
  assign flags.open_load        = load_flag;

  wire trigger_w = |(flags & ~flags_prev);

  always_comb begin
    next_os_state = os_state;
    next_os_cnt   = os_cnt;
    unique case (os_state)
      qdfd_pkg::QDFD_IDLE: begin
        if (trigger_w) begin
          next_os_state = qdfd_pkg::QDFD_PULSE;
          next_os_cnt   = qdfd_pkg::INT_CNT_ZERO;
        end
      end
      qdfd_pkg::QDFD_PULSE: begin
        if (os_cnt == qdfd_pkg::INT_CNT_LAST)
          next_os_state = qdfd_pkg::QDFD_IDLE;
        else
          next_os_cnt = os_cnt + 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      os_state   <= qdfd_pkg::QDFD_IDLE;
      os_cnt     <= qdfd_pkg::INT_CNT_ZERO;
      flags_prev <= '0;
    end else begin
      os_state   <= next_os_state;
      os_cnt     <= next_os_cnt;
      flags_prev <= flags;
    end
  end

  assign int_active = (os_state == qdfd_pkg::QDFD_PULSE);
  assign int_o      = 1'b0;
  assign int_oe_n_o = ~int_active;

  qdfd_shift u_shift (
    .sck_i      (sck_i),
    .cs_n_i     (cs_n_i),
    .sdi_i      (sdi_i),
    .flags_i    (flags),
    .sdo_o      (sdo_o),
    .sdo_oe_n_o (sdo_oe_n_o)
  );

  // helper: cycles the current interrupt pulse has lasted
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      int_len <= '0;
    else if (int_active)
      int_len <= int_len + 1'b1;
    else
      int_len <= '0;
  end

  // helper: channels being limited but not tripping
  assign limit_hold = current_limit_o & ~temp_s;

  // a_int_pulse_len
  a_int_pulse_len: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    $fell(int_active) |->
      (int_len >= qdfd_pkg::T_INT_MIN_US * qdfd_pkg::CLK_MHZ) &&
      (int_len <= qdfd_pkg::T_INT_MAX_US * qdfd_pkg::CLK_MHZ))
    else $error("interrupt pulse length out of range");
  // a_int_ends_bound
  a_int_ends_bound: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    $rose(int_active) |-> ##[1:600] !int_active)
    else $error("interrupt pulse too long");
  // a_trigger_starts
  a_trigger_starts: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (trigger_w && !int_active)
      |=> int_active && os_cnt == qdfd_pkg::INT_CNT_ZERO)
    else $error("trigger did not start interrupt");
  // a_lockout_hold
  a_lockout_hold: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (int_active && os_cnt != qdfd_pkg::INT_CNT_LAST)
      |=> int_active && os_cnt == $past(os_cnt) + 1'b1)
    else $error("lockout restarted the pulse");
  // a_reset_gates_off
  a_reset_gates_off: assert property (@(posedge core_clk_i)
    !rst_n_i |-> gate_on_o == '0 && flags == '0)
    else $error("reset left gate or flag set");
  // a_limit_no_off
  a_limit_no_off: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    (|limit_hold) |=> ($past(limit_hold) & ctrl_s & ~gate_on_o) == '0)
    else $error("current limit switched gate off");
  // a_open_in_int
  a_open_in_int: assert property (@(posedge core_clk_i)
    disable iff (!rst_n_i)
    ($rose(load_flag[qdfd_pkg::NUM_CH-1]) && !int_active) |=> int_active)
    else $error("open-load did not raise interrupt");
endmodule : qdfd_top
`default_nettype wire

/* File: sim/qdfd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module qdfd_host (
  // frame request and result
  input  wire logic       start_i,
  output logic            done_o,
  output logic [7:0]      data_o,
  // serial link
  output logic            sck_o,
  output logic            cs_n_o,
  output logic            sdi_o,
  input  wire logic       sdo_i,
  input  wire logic       sdo_oe_n_i
);
  logic last;
  // released line shows the inverse of its last value
  wire  line = sdo_oe_n_i ? ~last : sdo_i;
  initial begin
    {done_o, data_o, sck_o, sdi_o, last} = '0;
    cs_n_o = 1'b1;
  end
  always @(posedge start_i) begin
    #1.7;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      data_o[i] = line;
      last = line;
      sck_o = 1'b1;
      sdi_o = ~sdi_o;
      #62.5;
      sck_o = 1'b0;
      #62.5;
    end
    cs_n_o = 1'b1;
    done_o = 1'b1;
    #62.5;
    done_o = 1'b0;
  end
endmodule : qdfd_host
`default_nettype wire

/* File: sim/tb_qdfd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_qdfd_top;
  logic       core_clk_i, rst_n_i, int_v, int_oe_n, sck, cs_n, sdi;
  logic       sdo, sdo_oe_n, start, done;
  logic [3:0] ctrl, hot, open, over_cur, gate_on, climit;
  logic [7:0] rd, exp_b, r;
  logic [7:0] exp_q[$];
  int         bad_count, total_checks, seed, cnt;
  wire        int_line = int_oe_n ? 1'b1 : int_v;
  qdfd_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .ctrl_i(ctrl), .over_temperature_i(hot), .open_load_i(open),
    .over_current_i(over_cur), .gate_on_o(gate_on), .current_limit_o(climit),
    .int_o(int_v), .int_oe_n_o(int_oe_n), .sck_i(sck), .cs_n_i(cs_n),
    .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n));
  qdfd_host host (.start_i(start), .done_o(done), .data_o(rd),
    .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo),
    .sdo_oe_n_i(sdo_oe_n));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t unexpected output", $time);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : cyc
  task automatic wait_int(input logic lvl);
    cnt = 0;
    while (int_line !== lvl) begin
      @(posedge core_clk_i);
      cnt++;
      if (cnt > 6000) begin
        bad_count++;
        stop_test();
      end
    end
  endtask : wait_int
  task automatic read(input logic [7:0] exp);
    int k;
    k = 0;
    exp_q.push_back(exp);
    start <= 1'b1;
    while (done !== 1'b1 && k < 400) begin
      @(posedge core_clk_i);
      k++;
    end
    chk(k < 400);
    if (k >= 400) begin
      stop_test();
    end
    start <= 1'b0;
    cyc(20);
  endtask : read
  // compare each finished frame with the oldest note
  always @(posedge done) begin
    exp_b = exp_q.pop_front();
    total_checks++;
    if (rd !== exp_b) begin
      bad_count++;
      $display("BAD %0t serial byte %h", $time, rd);
    end
  end
  initial begin
    seed = 32'h473eecdc;
    {ctrl, hot, open, over_cur, start} = '0;
    rst_n_i = 1'b0;
    cyc(2);
    chk(gate_on === 4'h0 && int_oe_n === 1'b1);
    rst_n_i <= 1'b1;
    ctrl[0] <= 1'b1;
    over_cur[0] <= 1'b1;
    cyc(6);
    chk(gate_on[0] === 1'b1 && climit[0] === 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      ctrl[3:2] <= r[1:0];
      over_cur[3:2] <= r[3:2];
      cyc(5);
      chk(gate_on[3:2] === r[1:0]);
      chk(climit[3:2] === (r[1:0] & r[3:2]));
    end
    hot[0] <= 1'b1;
    wait_int(1'b0);
    chk(cnt <= 8);
    open[1] <= 1'b1;
    wait_int(1'b1);
    chk(cnt >= 600 && cnt <= 5000);
    chk(gate_on[0] === 1'b0 && gate_on[1] === 1'b0);
    cnt = 0;
    repeat (700) begin
      @(posedge core_clk_i);
      if (int_line !== 1'b1) cnt++;
    end
    chk(cnt == 0);
    read(8'h21);
    ctrl[0] <= 1'b0;
    cyc(6);
    ctrl[0] <= 1'b1;
    cyc(8);
    chk(gate_on[0] === 1'b0);
    read(8'h21);
    hot[0] <= 1'b0;
    ctrl[0] <= 1'b0;
    cyc(6);
    ctrl[0] <= 1'b1;
    cyc(8);
    chk(gate_on[0] === 1'b1);
    read(8'h20);
    ctrl[1] <= 1'b1;
    cyc(8);
    chk(gate_on[1] === 1'b1);
    ctrl[1] <= 1'b0;
    cyc(8);
    read(8'h20);
    open[1] <= 1'b0;
    ctrl[1] <= 1'b1;
    cyc(6);
    ctrl[1] <= 1'b0;
    cyc(8);
    read(8'h00);
    ctrl[2] <= 1'b0;
    hot[2] <= 1'b1;
    cyc(8);
    read(8'h04);
    rst_n_i <= 1'b0;
    cyc(2);
    chk(gate_on === 4'h0 && int_oe_n === 1'b1);
    hot[2] <= 1'b0;
    rst_n_i <= 1'b1;
    cyc(6);
    read(8'h00);
    ctrl[3] <= 1'b0;
    open[3] <= 1'b1;
    wait_int(1'b0);
    chk(cnt <= 8);
    read(8'h80);
    stop_test();
  end
endmodule : tb_qdfd_top
`default_nettype wire
